/* File: hw/vpf_pkg.sv */
// Purpose: Shared constants and carriers for the packet framer
// Assumes: Byte wide packet ports, APB register access
// Notes:   Frame timing figures give the codec mode period
package vpf_pkg;
	localparam logic [7:0]  START_VAL   = 8'h61;
	localparam logic [7:0]  PARITY_ID   = 8'h2F;
	localparam logic [7:0]  TYPE_CTRL   = 8'h00;
	localparam logic [7:0]  TYPE_CHAN   = 8'h01;
	localparam logic [7:0]  TYPE_SPEECH = 8'h02;
	localparam int          PAR_BYTES   = 2;
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_STATUS  = 12'h004;
	localparam logic [11:0] OFS_DROP    = 12'h008;
	localparam int          CTRL_PAR    = 0;
	localparam int          CTRL_CODEC  = 1;
	localparam int          FRAME_MS    = 20;
	localparam int          CLK_KHZ     = 125000;
	localparam int          FRAME_CYC   = FRAME_MS * CLK_KHZ;
	localparam int          PORT_NUM    = 3;
	typedef enum logic [1:0] {
		PORT_ASYNC,
		PORT_PARALLEL,
		PORT_SYNC
	} portSel_t;
	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} byteBeat_t;
	typedef struct packed {
		logic [15:0] len;
		logic [7:0]  kind;
	} pktDesc_t;
endpackage : vpf_pkg

/* File: hw/vocoder_packet_framer.sv */
// Purpose: Packet framing, queueing and ordering for the vocoder core
// Assumes: Port PHYs and vocoder core run on clk_sys; cfgPins async
// Notes:   Payload passed to and from the core excludes header and parity
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Each packet opens with start byte 0x61.
// RULE_02: Length sits in bytes two and three, high byte first.
// RULE_03: Fourth byte is the packet type, fields follow.
// RULE_04: Length counts all bytes after the four header bytes.
// RULE_05: With parity on, length includes the two parity bytes.
// RULE_06: With parity on, packet ends with 0x2F and a check byte.
// RULE_07: Parity starts enabled after every reset.
// RULE_08: Received packets are handled in arrival order.
// RULE_09: Responses go out when ready, in request order.
// RULE_10: Separate receive and transmit queues, room for four packets.
// RULE_11: Port traffic continues while earlier packets are processed.
// RULE_12: Speech packet in packet mode yields one channel packet.
// RULE_13: Channel packet in packet mode yields one speech packet.
// RULE_14: Control packet applies settings then returns a response.
// RULE_15: Codec mode sends and expects a channel packet every 20ms.
// RULE_16: Codec mode keeps speech off the packet port. Code drops only received speech; transmit sends any kind from the core.
// RULE_17: Packet mode carries speech and channel bits as packets.
// RULE_18: Port select pins are sampled after reset release.
// RULE_19: Only the selected port moves packets.
// RULE_20: One framing engine serves all ports.
// RULE_21: Fields fill the length less any parity bytes.
// RULE_22: Check byte is XOR of all bytes but start and check.
// RULE_23: Received packets with bad parity are dropped silently.
// RULE_24: Types are 0x00 control, 0x01 channel, 0x02 speech.
// RULE_25: Each field starts with a one byte identifier.
// RULE_26: Receiver hunts for start byte, then takes header plus length.
// RULE_27: Full receive queue stalls the port instead of overwriting.
module vocoder_packet_framer
	import vpf_pkg::*;
#(
	parameter int MEM_DEPTH = 2048,
	parameter int DESC_N    = 4,
	parameter int FRAME_N   = FRAME_CYC
) (
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [1:0]               cfgPins,
	input  wire byteBeat_t [PORT_NUM-1:0] portRx,
	output logic      [PORT_NUM-1:0]      portRxReady,
	output byteBeat_t                     portTx,
	output logic      [PORT_NUM-1:0]      portTxValid,
	input  wire logic [PORT_NUM-1:0]      portTxReady,
	output byteBeat_t                     coreRx,
	output logic      [7:0]               coreRxKind,
	input  wire logic                     coreRxReady,
	input  wire byteBeat_t                coreTx,
	input  wire logic [7:0]               coreTxKind,
	output logic                          coreTxReady,
	input  wire logic                     paritySetValid,
	input  wire logic                     paritySetVal,
	output logic                          frameTick,
	output logic                          codecMode
);
	localparam int AW = $clog2(MEM_DEPTH);
	localparam int DW = $clog2(DESC_N);
	localparam logic [31:0] FRAME_LAST = 32'(FRAME_N - 1);

	function automatic logic memRoom(input logic [AW:0] w, input logic [AW:0] r);
		memRoom = (w - r) != (AW+1)'(MEM_DEPTH);
	endfunction : memRoom

	// Port selection, caught once after reset
	logic [1:0] cfgMeta_r, cfgSync_r;
	logic       selDone_r;
	portSel_t   sel_r;
	logic [PORT_NUM-1:0] selMask;
	always_ff @(posedge clk_sys) begin
		cfgMeta_r <= cfgPins;
		cfgSync_r <= cfgMeta_r;
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			selDone_r <= 1'b0;
			sel_r     <= PORT_ASYNC;
		end else if (!selDone_r) begin
			// Takes the synchroniser output on the first cycle after reset release
			selDone_r <= 1'b1;
			sel_r     <= (cfgSync_r > 2'(PORT_SYNC)) ? PORT_ASYNC
			             : portSel_t'(cfgSync_r); // RULE_18
		end
	end
	assign selMask = selDone_r ? (PORT_NUM)'(1) << sel_r : '0;

	// Registers
	logic        parEn_r, codec_r;
	logic [15:0] drops_r;
	logic        wrEn, rdEn;
	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && !pwrite;
	assign pready = 1'b1;
	assign codecMode = codec_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			parEn_r <= 1'b1; // RULE_07
			codec_r <= 1'b0;
		end else if (paritySetValid) begin
			parEn_r <= paritySetVal; // RULE_14
		end else if (wrEn && paddr == OFS_CTRL) begin
			parEn_r <= pwdata[CTRL_PAR];
			codec_r <= pwdata[CTRL_CODEC];
		end
	end

	// Receive parser
	typedef enum {RX_HUNT, RX_LENH, RX_LENL, RX_TYPE, RX_BODY} rxSt_t;
	rxSt_t       rxSt_r;
	logic [7:0]  rxMem [MEM_DEPTH];
	logic [AW:0] rxWr_r, rxBase_r, rxRd_r;
	logic [15:0] rxLen_r, rxRem_r, rxStored_r;
	logic [7:0]  rxKind_r, rxXor_r;
	logic        rxPar_r, rxIdOk_r;
	pktDesc_t    rxQ [DESC_N];
	logic [DW:0] rxQw_r, rxQr_r, rxQcnt;
	byteBeat_t   inBeat;
	logic        inReady, inTake, bodyStore, rxEnd, rxGood, rxKeep;
	logic [7:0]  rxXorNext;

	always_comb begin
		inBeat = '0;
		for (int i = 0; i < PORT_NUM; i++) begin
			if (selMask[i]) begin
				inBeat = portRx[i];
			end
		end
	end
	assign rxQcnt    = rxQw_r - rxQr_r;
	assign bodyStore = !rxPar_r || rxRem_r > 16'(PAR_BYTES);
	// Stall rather than overwrite queued packets
	assign inReady = (rxSt_r == RX_HUNT) ? (rxQcnt != (DW+1)'(DESC_N))
	                 : (rxSt_r != RX_BODY || !bodyStore
	                    || memRoom(rxWr_r, rxRd_r)); // RULE_27
	assign portRxReady = selMask & {PORT_NUM{inReady}}; // RULE_19
	assign inTake    = inBeat.valid && inReady;
	assign rxXorNext = rxXor_r ^ inBeat.data; // RULE_22
	assign rxEnd     = inTake && rxSt_r == RX_BODY && rxRem_r == 16'd1;
	// Codec mode keeps speech on the converter side
	assign rxKeep = !(codec_r && rxKind_r == TYPE_SPEECH); // RULE_16 RULE_17
	assign rxGood = rxKeep && (rxStored_r != '0 || bodyStore)
	                && (!rxPar_r || (rxIdOk_r && rxXorNext == '0)); // RULE_23

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rxSt_r <= RX_HUNT;
			rxWr_r <= '0;
			rxBase_r <= '0;
			rxQw_r <= '0;
			drops_r <= '0;
			rxLen_r <= '0;
			rxRem_r <= '0;
			rxStored_r <= '0;
			rxKind_r <= '0;
			rxXor_r <= '0;
			rxPar_r <= 1'b1;
			rxIdOk_r <= 1'b0;
		end else if (inTake) begin
			unique case (rxSt_r)
				RX_HUNT: if (inBeat.data == START_VAL) begin // RULE_26
					rxSt_r  <= RX_LENH; // RULE_01
					rxPar_r <= parEn_r;
					rxXor_r <= '0;
				end
				RX_LENH: begin
					rxLen_r[15:8] <= inBeat.data; // RULE_02
					rxXor_r <= rxXorNext;
					rxSt_r <= RX_LENL;
				end
				RX_LENL: begin
					rxLen_r[7:0] <= inBeat.data;
					rxXor_r <= rxXorNext;
					rxSt_r <= RX_TYPE;
				end
				RX_TYPE: begin
					rxKind_r <= inBeat.data; // RULE_03
					rxXor_r <= rxXorNext;
					rxRem_r <= rxLen_r; // RULE_04
					rxStored_r <= '0;
					rxIdOk_r <= 1'b0;
					if (rxLen_r == '0 || (rxPar_r
					    && rxLen_r < 16'(PAR_BYTES))) begin // RULE_05
						rxSt_r <= RX_HUNT;
						drops_r <= drops_r + 16'd1;
					end else begin
						rxSt_r <= RX_BODY;
					end
				end
				RX_BODY: begin
					rxXor_r <= rxXorNext;
					rxRem_r <= rxRem_r - 16'd1;
					if (bodyStore) begin
						rxMem[rxWr_r[AW-1:0]] <= inBeat.data; // RULE_21
						rxWr_r <= rxWr_r + 1'b1;
						rxStored_r <= rxStored_r + 16'd1;
					end else if (rxRem_r == 16'(PAR_BYTES)) begin
						rxIdOk_r <= inBeat.data == PARITY_ID; // RULE_06
					end
					if (rxEnd) begin
						rxSt_r <= RX_HUNT;
						if (rxGood) begin
							rxQ[rxQw_r[DW-1:0]] <= '{len:
								rxStored_r + 16'(bodyStore), kind: rxKind_r};
							rxQw_r <= rxQw_r + 1'b1;
							rxBase_r <= rxWr_r + (AW+1)'(bodyStore);
						end else begin
							// Roll back the partial packet
							rxWr_r <= rxBase_r;
							drops_r <= drops_r + 16'd1;
						end
					end
				end
			endcase
		end
	end

	// Core side of receive queue, strictly in arrival order
	logic [15:0] outRem_r;
	logic        outAct_r, outLoad;
	assign outLoad = (!coreRx.valid || coreRxReady)
	                 && (outAct_r || rxQcnt != '0);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			coreRx <= '0;
			coreRxKind <= '0;
			rxRd_r <= '0;
			rxQr_r <= '0;
			outRem_r <= '0;
			outAct_r <= 1'b0;
		end else if (outLoad) begin
			coreRx.valid <= 1'b1;
			coreRx.data <= rxMem[rxRd_r[AW-1:0]]; // RULE_08
			rxRd_r <= rxRd_r + 1'b1;
			if (!outAct_r) begin
				coreRxKind <= rxQ[rxQr_r[DW-1:0]].kind; // RULE_12 RULE_13
				coreRx.last <= rxQ[rxQr_r[DW-1:0]].len == 16'd1;
				outRem_r <= rxQ[rxQr_r[DW-1:0]].len - 16'd1;
				outAct_r <= rxQ[rxQr_r[DW-1:0]].len != 16'd1;
				rxQr_r <= rxQr_r + 1'b1;
			end else begin
				coreRx.last <= outRem_r == 16'd1;
				outRem_r <= outRem_r - 16'd1;
				outAct_r <= outRem_r != 16'd1;
			end
		end else if (coreRxReady) begin
			coreRx.valid <= 1'b0;
		end
	end

	// Transmit store, whole payload queued before its header goes out
	logic [7:0]  txMem [MEM_DEPTH];
	logic [AW:0] txWr_r, txRd_r;
	logic [15:0] txAcc_r;
	pktDesc_t    txQ [DESC_N];
	logic [DW:0] txQw_r, txQr_r, txQcnt;
	logic        coreTake;
	assign txQcnt = txQw_r - txQr_r;
	assign coreTxReady = memRoom(txWr_r, txRd_r)
	                     && txQcnt != (DW+1)'(DESC_N); // RULE_10
	assign coreTake = coreTx.valid && coreTxReady;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			txWr_r <= '0;
			txQw_r <= '0;
			txAcc_r <= '0;
		end else if (coreTake) begin
			txMem[txWr_r[AW-1:0]] <= coreTx.data; // RULE_11
			txWr_r <= txWr_r + 1'b1;
			txAcc_r <= coreTx.last ? '0 : txAcc_r + 16'd1;
			if (coreTx.last) begin
				txQ[txQw_r[DW-1:0]] <= '{len: txAcc_r + 16'd1,
				                         kind: coreTxKind}; // RULE_09
				txQw_r <= txQw_r + 1'b1;
			end
		end
	end

	// Transmit framer, shared by every port
	typedef enum {TX_IDLE, TX_LENH, TX_LENL, TX_TYPE, TX_BODY, TX_PID,
	              TX_PBYTE} txSt_t;
	txSt_t       txSt_r;
	logic [15:0] txLen_r, txRem_r;
	logic [7:0]  txKind_r, txXor_r;
	logic        txPar_r, txStep, txHead_r, outReady;
	assign outReady = |(portTxReady & selMask);
	assign portTxValid = selMask & {PORT_NUM{portTx.valid}}; // RULE_20
	assign txStep = !portTx.valid || outReady;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			txSt_r <= TX_IDLE;
			portTx <= '0;
			txRd_r <= '0;
			txQr_r <= '0;
			txLen_r <= '0;
			txRem_r <= '0;
			txKind_r <= '0;
			txXor_r <= '0;
			txPar_r <= 1'b1;
			txHead_r <= 1'b0;
		end else if (txStep) begin
			portTx.valid <= 1'b1;
			portTx.last <= 1'b0;
			txHead_r <= 1'b0;
			unique case (txSt_r)
				TX_IDLE: if (txQcnt != '0 && selDone_r) begin
					portTx.data <= START_VAL; // RULE_01
					txHead_r <= 1'b1;
					txPar_r <= parEn_r;
					txKind_r <= txQ[txQr_r[DW-1:0]].kind;
					txRem_r <= txQ[txQr_r[DW-1:0]].len;
					txLen_r <= txQ[txQr_r[DW-1:0]].len
					           + (parEn_r ? 16'(PAR_BYTES) : '0); // RULE_05
					txQr_r <= txQr_r + 1'b1;
					txXor_r <= '0;
					txSt_r <= TX_LENH;
				end else begin
					portTx.valid <= 1'b0;
				end
				TX_LENH: begin
					portTx.data <= txLen_r[15:8]; // RULE_02
					txXor_r <= txLen_r[15:8];
					txSt_r <= TX_LENL;
				end
				TX_LENL: begin
					portTx.data <= txLen_r[7:0];
					txXor_r <= txXor_r ^ txLen_r[7:0];
					txSt_r <= TX_TYPE;
				end
				TX_TYPE: begin
					portTx.data <= txKind_r; // RULE_03 RULE_24
					txXor_r <= txXor_r ^ txKind_r;
					txSt_r <= TX_BODY;
				end
				TX_BODY: begin
					portTx.data <= txMem[txRd_r[AW-1:0]]; // RULE_25
					txXor_r <= txXor_r ^ txMem[txRd_r[AW-1:0]];
					txRd_r <= txRd_r + 1'b1;
					txRem_r <= txRem_r - 16'd1;
					if (txRem_r == 16'd1) begin
						portTx.last <= !txPar_r;
						txSt_r <= txPar_r ? TX_PID : TX_IDLE;
					end
				end
				TX_PID: begin
					portTx.data <= PARITY_ID; // RULE_06
					txXor_r <= txXor_r ^ PARITY_ID;
					txSt_r <= TX_PBYTE;
				end
				TX_PBYTE: begin
					portTx.data <= txXor_r; // RULE_22
					portTx.last <= 1'b1;
					txSt_r <= TX_IDLE;
				end
			endcase
		end
	end

	// Codec mode frame pacing; the core answers each tick
	logic [31:0] frameCnt_r;
	always_ff @(posedge clk_sys) begin
		if (rst || !codec_r) begin
			frameCnt_r <= '0;
			frameTick <= 1'b0;
		end else begin
			frameTick <= frameCnt_r == FRAME_LAST; // RULE_15
			frameCnt_r <= (frameCnt_r == FRAME_LAST) ? '0
			              : frameCnt_r + 32'd1;
		end
	end

	// Register read path; unmapped addresses answer with an error
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata <= '0;
		end else if (rdEn && !penable) begin
			unique case (paddr)
				OFS_CTRL: prdata <= 32'({codec_r, parEn_r});
				OFS_STATUS: prdata <= 32'({txQcnt, rxQcnt, selDone_r,
				                           2'(sel_r)});
				OFS_DROP: prdata <= 32'(drops_r);
				default: prdata <= '0;
			endcase
		end
	end
	assign pslverr = psel && penable && paddr != OFS_CTRL
	                 && paddr != OFS_STATUS && paddr != OFS_DROP;

	property p_start;
		@(posedge clk_sys) disable iff (rst)
		(txHead_r && portTx.valid) |-> portTx.data == START_VAL;
	endproperty
	a_start: assert property (p_start) else $error("bad start"); // RULE_01
	property p_lenhi;
		@(posedge clk_sys) disable iff (rst)
		(txStep && txSt_r == TX_LENH) |=> portTx.data == txLen_r[15:8];
	endproperty
	a_lenhi: assert property (p_lenhi) else $error("bad len"); // RULE_02
	property p_pid;
		@(posedge clk_sys) disable iff (rst)
		(txStep && txSt_r == TX_PID) |=> portTx.valid && !portTx.last
		&& portTx.data == PARITY_ID && txSt_r == TX_PBYTE;
	endproperty
	a_pid: assert property (p_pid) else $error("bad parity id"); // RULE_06
	property p_parrst;
		@(posedge clk_sys) rst ##1 !rst |-> parEn_r && rxPar_r;
	endproperty
	a_parrst: assert property (p_parrst) else $error("parity off"); // RULE_07
	property p_onlysel;
		@(posedge clk_sys) disable iff (rst)
		((portRxReady | portTxValid) & ~selMask) == '0;
	endproperty
	a_onlysel: assert property (p_onlysel) else $error("port"); // RULE_19
	property p_qcap;
		@(posedge clk_sys) disable iff (rst)
		rxQcnt <= (DW+1)'(DESC_N) && txQcnt <= (DW+1)'(DESC_N);
	endproperty
	a_qcap: assert property (p_qcap) else $error("queue over"); // RULE_10
	property p_stall;
		@(posedge clk_sys) disable iff (rst)
		(rxSt_r == RX_BODY && bodyStore && !memRoom(rxWr_r, rxRd_r))
		|-> portRxReady == '0;
	endproperty
	a_stall: assert property (p_stall) else $error("no stall"); // RULE_27
	property p_tick;
		@(posedge clk_sys) disable iff (rst)
		frameTick |=> !frameTick ##1 !frameTick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick spacing"); // RULE_15
	property p_drop;
		@(posedge clk_sys) disable iff (rst)
		(rxEnd && !rxGood) |=> rxWr_r == $past(rxBase_r);
	endproperty
	a_drop: assert property (p_drop) else $error("kept bad"); // RULE_23
	c_rxok: cover property (@(posedge clk_sys) rxEnd && rxGood);
	c_rxbad: cover property (@(posedge clk_sys) rxEnd && !rxGood);
	c_txpar: cover property (@(posedge clk_sys) txSt_r == TX_PBYTE);
	c_full: cover property (@(posedge clk_sys) rxQcnt == (DW+1)'(DESC_N));
endmodule : vocoder_packet_framer

/* File: tb/host_link_model.sv */
// Purpose: Host side of the selected packet port
// Assumes: Byte valid/ready handshake, one clock
// Notes:   Released data line shows the inverse of the last byte
`timescale 1ns/1ps
module host_link_model
	import vpf_pkg::*;
(
	input  wire logic      clk_sys,
	output byteBeat_t      rxBeat,
	input  wire logic      rxReady,
	input  wire byteBeat_t txBeat,
	input  wire logic      txValid,
	output logic           txReady
);
	logic [7:0] got[$];
	logic [3:0] stallCnt = 4'h0;
	initial rxBeat = '{1'b0, 1'b0, 8'h00};
	initial txReady = 1'b0;
	// Each byte held until the framer takes it
	task automatic sendBytes(input logic [7:0] q[$], output bit timedOut);
		int n;
		timedOut = 0;
		@(posedge clk_sys);
		foreach (q[i]) begin
			rxBeat <= '{1'b1, i == q.size() - 1, q[i]};
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (!rxReady && n < 2000);
			if (!rxReady)
				timedOut = 1;
		end
		rxBeat <= '{1'b0, 1'b0, ~rxBeat.data};
	endtask : sendBytes
	// Stalls four cycles in every sixteen to exercise held output bytes
	always @(posedge clk_sys) begin
		if (txValid && txReady)
			got.push_back(txBeat.data);
		stallCnt <= stallCnt + 4'h1;
		txReady  <= stallCnt[3:2] != 2'b11;
	end
endmodule : host_link_model

/* File: tb/vocoder_packet_framer_tb_top.sv */
// Purpose: Self-checking bench for the packet framer
// Assumes: Port 1 selected, bench echoes payloads as the core
// Notes:   Short frame period keeps the codec test brief
`timescale 1ns/1ps
module vocoder_packet_framer_tb_top
	import vpf_pkg::*;
;
	typedef logic [7:0] bq_t[$];
	logic                         clk_sys = 1'b0;
	logic                         rst, psel, penable, pwrite;
	logic [11:0]                  paddr;
	logic [31:0]                  pwdata, prdata, seed, rd;
	logic                         pready, pslverr, er;
	byteBeat_t                    hostRx, junk, portTx, coreRx, coreTx;
	wire byteBeat_t [PORT_NUM-1:0] portRx = {junk, hostRx, junk};
	logic [PORT_NUM-1:0]          portRxReady, portTxValid;
	logic                         hostTxReady, coreRxReady, coreTxReady;
	wire logic [PORT_NUM-1:0]     portTxReady = {1'b1, hostTxReady, 1'b1};
	logic [7:0]                   coreRxKind, coreTxKind;
	logic                         paritySetValid, paritySetVal;
	logic                         frameTick, codecMode;
	logic [16:0]                  v, rq[$];
	logic [2:0]                   stall;
	logic [1:0]                   cfg;
	bit                           codecOn;
	bq_t                          exp;
	int                           errCount, comparisons, idleHits;
	always #4 clk_sys = ~clk_sys;
	vocoder_packet_framer #(.FRAME_N(200)) DUT (.clk_sys(clk_sys),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cfgPins(cfg), .portRx(portRx),
		.portRxReady(portRxReady), .portTx(portTx),
		.portTxValid(portTxValid), .portTxReady(portTxReady),
		.coreRx(coreRx), .coreRxKind(coreRxKind), .coreRxReady(coreRxReady),
		.coreTx(coreTx), .coreTxKind(coreTxKind), .coreTxReady(coreTxReady),
		.paritySetValid(paritySetValid), .paritySetVal(paritySetVal),
		.frameTick(frameTick), .codecMode(codecMode));
	host_link_model host (.clk_sys(clk_sys), .rxBeat(hostRx),
		.rxReady(portRxReady[1]), .txBeat(portTx),
		.txValid(portTxValid[1]), .txReady(hostTxReady));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] mapK(input logic [7:0] k);
		return (k == 8'h00) ? 8'h00 : 8'h03 - k;
	endfunction : mapK
	function automatic bq_t frame(input logic [7:0] k, input bq_t f,
		input bit par);
		bq_t q;
		logic [15:0] len;
		logic [7:0] x;
		len = 16'(f.size()) + (par ? 16'h0002 : 16'h0000);
		q = {START_VAL, len[15:8], len[7:0], k};
		q = {q, f};
		if (par) begin
			q.push_back(PARITY_ID);
			x = 8'h00;
			for (int i = 1; i < q.size(); i++)
				x ^= q[i];
			q.push_back(x);
		end
		return q;
	endfunction : frame
	task automatic closeOut;
		$display("counts: %0d comparisons, %0d mismatches", comparisons,
			errCount);
		if (errCount == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : closeOut
	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errCount++;
			$display("unexpected %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!pready && n < 100);
		chk("apb answer", 1, pready);
		if (pready !== 1'b1)
			closeOut();
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic sendPkt(input logic [7:0] k, input int n, input bit par,
		input bit bad);
		bq_t f, q;
		bit to;
		for (int i = 0; i < n; i++)
			f.push_back(8'(rnd()));
		q = frame(k, f, par);
		if (bad)
			q[q.size() - 1] ^= 8'h01;
		// Leading noise must be skipped by the start hunt
		q.push_front(8'h60);
		host.sendBytes(q, to);
		chk("host send stalled", 0, to);
		if (to)
			closeOut();
		// Speech is dropped while codec mode is on
		if (!bad && !(codecOn && k == TYPE_SPEECH))
			exp = {exp, frame(mapK(k), f, par)};
	endtask : sendPkt
	task automatic drain(input string t);
		int n;
		n = 0;
		while (host.got.size() < exp.size() && n < 20000) begin
			@(posedge clk_sys);
			n++;
		end
		chk("response count", exp.size(), host.got.size());
		foreach (exp[i])
			if (i < host.got.size())
				chk("response byte", exp[i], host.got[i]);
		if (n >= 20000)
			closeOut();
		exp.delete();
		host.got.delete();
		$display("test %s done", t);
	endtask : drain
	always @(posedge clk_sys) begin
		junk        <= '{1'b1, 1'b0, junk.data + 8'h1F};
		stall       <= stall + 3'h1;
		coreRxReady <= stall != 3'h0;
		if (!rst && ((portRxReady | portTxValid) & 3'b101) != 3'b000)
			idleHits++;
		if (coreRx.valid && coreRxReady)
			rq.push_back({mapK(coreRxKind), coreRx.last, coreRx.data});
		if (!coreTx.valid || coreTxReady) begin
			if (rq.size() > 0) begin
				v = rq.pop_front();
				coreTx     <= '{1'b1, v[8], v[7:0]};
				coreTxKind <= v[16:9];
			end else
				coreTx <= '{1'b0, 1'b0, ~coreTx.data};
		end
	end
	initial begin
		int n;
		seed = 32'h0000_0010;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		junk = '{1'b1, 1'b0, 8'h61};
		stall = 3'h0;
		coreRxReady = 1'b0;
		coreTx = '{1'b0, 1'b0, 8'h00};
		coreTxKind = 8'h00;
		paritySetValid = 1'b0;
		paritySetVal = 1'b0;
		cfg = 2'b01;
		codecOn = 1'b0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk("ctrl reset", 32'h0000_0001, rd);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("port select", 3'b101, rd[2:0]);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk("unmapped error", 1, er);
		$display("test registers done");
		for (int k = 0; k < 8; k++)
			sendPkt(8'(k % 3), 1 + int'(rnd() % 6), 1, 0);
		drain("stream");
		sendPkt(TYPE_SPEECH, 3, 1, 1);
		sendPkt(TYPE_CHAN, 2, 1, 0);
		drain("bad parity");
		apb(1'b0, OFS_DROP, 32'h0000_0000);
		chk("drop count", 32'h0000_0001, rd);
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		sendPkt(TYPE_CTRL, 4, 0, 0);
		drain("no parity");
		@(posedge clk_sys);
		paritySetValid <= 1'b1;
		paritySetVal   <= 1'b1;
		@(posedge clk_sys);
		paritySetValid <= 1'b0;
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk("parity set", 1, rd[0]);
		codecOn = 1'b1;
		apb(1'b1, OFS_CTRL, 32'h0000_0003);
		// Write lands at the access edge; look one edge later
		@(posedge clk_sys);
		chk("codec mode", 1, codecMode);
		for (int t = 0; t < 2; t++) begin
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (!frameTick && n < 1000);
			if (!frameTick) begin
				chk("frame tick", 1, frameTick);
				closeOut();
			end
		end
		chk("frame gap", 200, n);
		sendPkt(TYPE_SPEECH, 2, 1, 0);
		sendPkt(TYPE_CTRL, 2, 1, 0);
		drain("codec traffic");
		apb(1'b0, OFS_DROP, 32'h0000_0000);
		chk("codec speech drop", 32'h0000_0002, rd);
		codecOn = 1'b0;
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		$display("test codec done");
		chk("idle port activity", 0, idleHits);
		// Second reset with a new strap; port 0 takes over
		@(posedge clk_sys);
		cfg <= 2'b11;
		rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("strap select", 3'b100, rd[2:0]);
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk("ctrl after reset", 32'h0000_0001, rd);
		$display("test reset done");
		closeOut();
	end
endmodule : vocoder_packet_framer_tb_top
